// *** inc/srw_params.svh ***
// Timing constants and reset values for the supervisor reset/watchdog block.
// Assumes a single 50 MHz reference clock.
`ifndef SRW_PARAMS_SVH
`define SRW_PARAMS_SVH

// ****************************************************************
// Clock
// ****************************************************************
`define SRW_CLK_HZ          50000000
// ****************************************************************
// Times in their own units and derived cycle counts
// ****************************************************************
`define SRW_RESET_TIMEOUT_MS 200
// Divide first: the plain product does not fit in a 32-bit int
`define SRW_RESET_CYCLES     (`SRW_RESET_TIMEOUT_MS * (`SRW_CLK_HZ / 1000))
`define SRW_WDOG_PERIOD_MS   1600
`define SRW_WDOG_CYCLES      (`SRW_WDOG_PERIOD_MS * (`SRW_CLK_HZ / 1000))
`define SRW_DEBOUNCE_US      5
`define SRW_DEBOUNCE_CYCLES  (`SRW_DEBOUNCE_US * (`SRW_CLK_HZ / 1000000))
// ****************************************************************
// Reset values
// ****************************************************************
`define SRW_BUTTON_RST_VAL   1'b1

`endif

// *** inc/srw_pkg.sv ***
// Types shared by the supervisor reset/watchdog design files.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package srw_pkg;
  typedef enum logic [1:0] {
    SRW_RUN     = 2'b00,
    SRW_HOLD    = 2'b01,
    SRW_TIMEOUT = 2'b10
  } srw_state_t;
endpackage
`default_nettype wire

// *** verilog/srw_debounce.sv ***
// Debouncer for the push-button reset input.
// Assumes the input is synchronous to ref_clk; idles high (pull-up inside).
`default_nettype none
`include "srw_params.svh"
module srw_debounce #(
  parameter int STABLE_CYCLES = `SRW_DEBOUNCE_CYCLES
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Raw and filtered level
  input  wire logic raw_in,
  output var  logic clean_q
);
  localparam int CW = $clog2(STABLE_CYCLES + 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          clean_d;

  always_comb begin
    cnt_d   = '0;
    clean_d = clean_q;
    if (raw_in != clean_q) begin
      if (cnt_q == CW'(STABLE_CYCLES - 1)) begin
        clean_d = raw_in;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q   <= '0;
      clean_q <= `SRW_BUTTON_RST_VAL;
    end else begin
      cnt_q   <= cnt_d;
      clean_q <= clean_d;
    end
  end

  bounce_filter_a: assert property (@(posedge ref_clk) disable iff (rst)
    (clean_q != $past(clean_q)) |-> $past(raw_in) == clean_q &&
    (STABLE_CYCLES < 2 || $past(raw_in, 2) == clean_q))
    else $error("debounced level changed without raw level");
endmodule
`default_nettype wire

// *** verilog/srw_supervisor.sv ***
// Supervisor core: combines low supply, push button, forced reset pin and
// watchdog into complementary resets with a stretched release; gates writes.
// Assumes all inputs synchronous to ref_clk; pad pull-ups/downs modelled here.
//
// Behaviour
// - Both reset outputs are active whenever low supply is indicated.
// - After supply recovers, resets stay active for the 200 ms timeout.
// - A high write-protect input blocks every array write; low allows them.
// - An unconnected write-protect input reads low, so writes are allowed.
// - No watchdog activity for 1.6 s drives the resets active.
// - Without a kick pin the watchdog watches serial data, else the kick input.
// - Any edge on the kick input restarts the period; the controller toggles it.
// - A low push-button input enters reset.
// - Resets hold while the button is low and for the timeout after release.
// - The button input is debounced before it acts.
// - An unconnected button input reads high, so no reset is requested.
// - Outside logic pulling the active-low reset pin low starts reset; the pin is ignored while we drive it, so reset ends after the timeout.
// - Writes are blocked while supply is low, including before first power-good.
`default_nettype none
`include "srw_params.svh"
module srw_supervisor #(
  parameter bit HAS_KICK_PIN   = 1'b1,
  parameter int RESET_CYCLES   = `SRW_RESET_CYCLES,
  parameter int WDOG_CYCLES    = `SRW_WDOG_CYCLES,
  parameter int DEBOUNCE_CYCLES = `SRW_DEBOUNCE_CYCLES
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Supply monitor
  input  wire logic supply_low,
  // Push button, pad connection flag (0 = floating)
  input  wire logic push_button_reset_n,
  input  wire logic push_button_connected,
  // Write protect, pad connection flag (0 = floating)
  input  wire logic write_protect,
  input  wire logic write_protect_connected,
  // Watchdog sources
  input  wire logic watchdog_kick_in,
  input  wire logic serial_data_in,
  // Active-low reset pin (open drain) and active-high reset output
  input  wire logic reset_pin_n_in,
  output var  logic reset_pin_n_out,
  output var  logic reset_pin_n_oe,
  output var  logic reset_out,
  // Memory write gate
  output var  logic write_inhibit
);
  localparam int TW = $clog2(RESET_CYCLES + 1);
  localparam int WW = $clog2(WDOG_CYCLES + 1);

  // ****************************************************************
  // Pad defaults and debounce
  // ****************************************************************
  logic button_level;
  logic button_clean_q;
  logic wp_level;

  assign button_level = push_button_connected ? push_button_reset_n : 1'b1;
  assign wp_level = write_protect_connected ? write_protect : 1'b0;

  srw_debounce #(
    .STABLE_CYCLES (DEBOUNCE_CYCLES)
  ) u_debounce (
    .ref_clk (ref_clk),
    .rst     (rst),
    .raw_in  (button_level),
    .clean_q (button_clean_q)
  );

  // ****************************************************************
  // Watchdog activity detect
  // ****************************************************************
  logic wd_src;
  logic wd_src_q;
  logic wd_edge;

  assign wd_src = HAS_KICK_PIN ? watchdog_kick_in : serial_data_in;
  assign wd_edge = wd_src ^ wd_src_q;

  // Reset to the idle level of the watched line: serial data idles high, so no false edge at release
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wd_src_q <= ~HAS_KICK_PIN;
    end else begin
      wd_src_q <= wd_src;
    end
  end

  // ****************************************************************
  // Reset sequencer
  // ****************************************************************
  srw_pkg::srw_state_t state_q;
  srw_pkg::srw_state_t state_d;
  logic [TW-1:0]       tmo_q;
  logic [TW-1:0]       tmo_d;
  logic [WW-1:0]       wd_q;
  logic [WW-1:0]       wd_d;
  logic                wd_expired;
  logic                ext_pin_low;
  logic                cause;
  logic                rst_act_d;
  logic                rst_act_q;
  logic                wi_d;
  logic                wi_q;

  // Pin low while we are not driving it means someone outside holds it
  assign ext_pin_low = ~reset_pin_n_in & ~rst_act_q;
  assign wd_expired  = (wd_q == WW'(WDOG_CYCLES - 1));
  assign cause = supply_low | ~button_clean_q | ext_pin_low;

  always_comb begin
    state_d   = state_q;
    tmo_d     = tmo_q;
    wd_d      = wd_q;
    rst_act_d = rst_act_q;
    case (state_q)
      srw_pkg::SRW_RUN: begin
        wd_d = wd_edge ? '0 : wd_q + 1'b1;
        if (cause || wd_expired) begin
          state_d   = srw_pkg::SRW_HOLD;
          rst_act_d = 1'b1;
          wd_d      = '0;
        end
      end
      srw_pkg::SRW_HOLD: begin
        wd_d  = '0;
        tmo_d = '0;
        if (!cause) begin
          state_d = srw_pkg::SRW_TIMEOUT;
        end
      end
      srw_pkg::SRW_TIMEOUT: begin
        wd_d = '0;
        if (cause) begin
          state_d = srw_pkg::SRW_HOLD;
        end else if (tmo_q == TW'(RESET_CYCLES - 1)) begin
          state_d   = srw_pkg::SRW_RUN;
          rst_act_d = 1'b0;
          tmo_d     = '0;
        end else begin
          tmo_d = tmo_q + 1'b1;
        end
      end
      default: begin
        state_d   = srw_pkg::SRW_HOLD;
        rst_act_d = 1'b1;
      end
    endcase
  end

  // Start in hold: the block must not release reset until supply was seen good
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q   <= srw_pkg::SRW_HOLD;
      tmo_q     <= '0;
      wd_q      <= '0;
      rst_act_q <= 1'b1;
    end else begin
      state_q   <= state_d;
      tmo_q     <= tmo_d;
      wd_q      <= wd_d;
      rst_act_q <= rst_act_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // write gate
  always_comb begin
    wi_d = wp_level | supply_low;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wi_q <= 1'b1;
    end else begin
      wi_q <= wi_d;
    end
  end

  assign reset_pin_n_out = 1'b0;
  assign reset_pin_n_oe  = rst_act_q;
  assign reset_out       = rst_act_q;
  assign write_inhibit   = wi_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  supply_low_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
    supply_low |=> ##1 reset_out)
    else $error("low supply did not assert reset");

  release_stretch_a: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(reset_out) |-> $past(state_q) == srw_pkg::SRW_TIMEOUT && $past(tmo_q) == TW'(RESET_CYCLES - 1))
    else $error("reset released before full timeout");

  wp_blocks_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    wp_level |=> write_inhibit)
    else $error("write protect did not inhibit writes");

  wp_allows_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!wp_level && !supply_low) |=> !write_inhibit)
    else $error("writes blocked without cause");

  wdog_expiry_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q == srw_pkg::SRW_RUN && wd_expired) |=> reset_out)
    else $error("watchdog expiry did not reset");

  wdog_restart_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q == srw_pkg::SRW_RUN && wd_edge && !cause && !wd_expired) |=> wd_q == '0)
    else $error("watchdog edge did not restart period");

  button_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
    !button_clean_q |=> ##1 reset_out)
    else $error("button press did not reset");

  pin_forced_a: assert property (@(posedge ref_clk) disable iff (rst)
    ext_pin_low |=> reset_out)
    else $error("forced reset pin not honoured");

  wdog_held_a: assert property (@(posedge ref_clk) disable iff (rst)
    reset_out |-> wd_q == '0)
    else $error("watchdog ran during reset");

  complement_a: assert property (@(posedge ref_clk) disable iff (rst)
    reset_pin_n_oe == reset_out && !reset_pin_n_out)
    else $error("reset outputs not complementary");
endmodule
`default_nettype wire

// *** tb/srw_host_model.sv ***
// Host controller model that feeds the supervisor's watchdog.
// Assumes in_reset is the supervisor's active-high reset output.
`default_nettype none
module srw_host_model #(
  parameter int MAX_GAP = 16
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Supervisor side
  input  wire logic in_reset,
  input  wire logic kick_en,
  input  wire logic sda_en,
  output var  logic kick_out,
  output var  logic sda_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  int gap = 3;
  // toggle within period
  // A held controller cannot run code, so no activity while in reset
  always @(posedge ref_clk) begin
    if (rst || in_reset) begin
      cnt <= 0;
      if (rst) begin
        kick_out <= 1'b0;
        sda_out  <= 1'b1;
      end
    end else if (cnt >= gap) begin
      cnt <= 0;
      gap <= 3 + $urandom_range(MAX_GAP - 3);
      if (kick_en) begin
        kick_out <= ~kick_out;
      end
      if (sda_en) begin
        sda_out <= ~sda_out;
      end
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// *** tb/supervisor_reset_watchdog_tb.sv ***
// Self-checking bench for the supervisor: kick-pin and serial-data variants.
// Assumes short timing parameters; the reset pin has an external pull-up.
`default_nettype none
module supervisor_reset_watchdog_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RST_C = 20;
  localparam int WD_C  = 40;
  localparam int DB_C  = 3;
  logic ref_clk    = 1'b0;
  logic rst        = 1'b1;
  logic supply_low = 1'b1;
  logic pb_n       = 1'b1;
  logic pb_con     = 1'b1;
  logic wp         = 1'b0;
  logic wp_con     = 1'b1;
  logic force_low  = 1'b0;
  logic kick_en    = 1'b0;
  logic sda_en     = 1'b0;
  logic kick, sda, pin_n, pin_out, pin_oe, reset_out, wi;
  logic pin2_n, pin2_out, pin2_oe, reset2_out;
  int   err_total   = 0;
  int   checks_done = 0;
  int   cycles      = 0;

  // Open drain with pull-up: low when the device or the bench pulls it
  assign pin_n  = ~((pin_oe & ~pin_out) | force_low);
  assign pin2_n = ~(pin2_oe & ~pin2_out);

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  srw_supervisor #(.HAS_KICK_PIN(1'b1), .RESET_CYCLES(RST_C), .WDOG_CYCLES(WD_C), .DEBOUNCE_CYCLES(DB_C)) uut (
    .ref_clk(ref_clk), .rst(rst), .supply_low(supply_low), .push_button_reset_n(pb_n),
    .push_button_connected(pb_con), .write_protect(wp), .write_protect_connected(wp_con),
    .watchdog_kick_in(kick), .serial_data_in(sda), .reset_pin_n_in(pin_n), .reset_pin_n_out(pin_out),
    .reset_pin_n_oe(pin_oe), .reset_out(reset_out), .write_inhibit(wi));
  srw_supervisor #(.HAS_KICK_PIN(1'b0), .RESET_CYCLES(RST_C), .WDOG_CYCLES(WD_C), .DEBOUNCE_CYCLES(DB_C)) uut_sda (
    .ref_clk(ref_clk), .rst(rst), .supply_low(supply_low), .push_button_reset_n(pb_n),
    .push_button_connected(pb_con), .write_protect(wp), .write_protect_connected(wp_con),
    .watchdog_kick_in(1'b0), .serial_data_in(sda), .reset_pin_n_in(pin2_n), .reset_pin_n_out(pin2_out),
    .reset_pin_n_oe(pin2_oe), .reset_out(reset2_out), .write_inhibit());
  srw_host_model hm_kick (.ref_clk(ref_clk), .rst(rst), .in_reset(reset_out), .kick_en(kick_en),
    .sda_en(1'b0), .kick_out(kick), .sda_out());
  srw_host_model hm_sda (.ref_clk(ref_clk), .rst(rst), .in_reset(reset2_out), .kick_en(1'b0),
    .sda_en(sda_en), .kick_out(), .sda_out(sda));

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task automatic chk(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t ns: got %b expected %b", $time, got, exp);
    end
  endtask
  // Counts cycles until reset_out reaches lvl; the wait must fall in [lo, hi)
  task automatic wait_lvl(input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while (reset_out !== lvl && n < hi) begin
      cyc(1);
      n++;
    end
    chk(n >= lo && n < hi, 1'b1);
  endtask
  function automatic logic exp_wi(input logic p, input logic c, input logic s);
    return (p & c) | s;
  endfunction
  task automatic finish_test;
    if (err_total == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // The whole sequence needs well under 1500 cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      finish_test();
    end
  end

  initial begin
    void'($urandom(32'h354a));
    cyc(10);
    rst = 1'b0;
    cyc(5);
    chk(reset_out, 1'b1);
    chk(pin_n, 1'b0);
    chk(wi, 1'b1);
    supply_low = 1'b0;
    kick_en = 1'b1;
    sda_en = 1'b1;
    wait_lvl(1'b0, RST_C - 2, RST_C + 5);
    for (int i = 0; i < 24; i++) begin
      wp = 1'($urandom);
      wp_con = 1'($urandom);
      supply_low = 1'(i == 23);
      cyc(2);
      chk(wi, exp_wi(wp, wp_con, supply_low));
    end
    chk(reset_out, 1'b1);
    supply_low = 1'b0;
    wait_lvl(1'b0, RST_C - 2, RST_C + 5);
    cyc(3 * WD_C);
    chk(reset_out, 1'b0);
    kick_en = 1'b0;
    wait_lvl(1'b1, WD_C - 20, WD_C + 4);
    chk(reset2_out, 1'b0);
    wait_lvl(1'b0, RST_C - 2, RST_C + 5);
    wait_lvl(1'b1, WD_C - 2, WD_C + 4);
    kick_en = 1'b1;
    wait_lvl(1'b0, RST_C - 2, RST_C + 5);
    pb_n = 1'b0;
    cyc(1);
    pb_n = 1'b1;
    cyc(DB_C + 4);
    chk(reset_out, 1'b0);
    pb_con = 1'b0;
    pb_n = 1'b0;
    cyc(DB_C + 4);
    chk(reset_out, 1'b0);
    pb_con = 1'b1;
    wait_lvl(1'b1, DB_C - 1, DB_C + 4);
    cyc(2 * RST_C);
    chk(reset_out, 1'b1);
    pb_n = 1'b1;
    wait_lvl(1'b0, RST_C - 2, RST_C + DB_C + 6);
    force_low = 1'b1;
    cyc(2);
    force_low = 1'b0;
    chk(reset_out, 1'b1);
    wait_lvl(1'b0, RST_C - 2, RST_C + 5);
    cyc(3);
    sda_en = 1'b0;
    cyc(WD_C + 4);
    chk(reset2_out, 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
